// *** core/lcfg_pkg.sv ***
// Package: register map, field layout, carrier types and decode functions
package lcfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_LOOP   = 8'h04;
  localparam logic [7:0] OFF_INOFF  = 8'h08;
  localparam logic [7:0] OFF_OUTOFF = 8'h0C;
  localparam logic [7:0] OFF_GRPA   = 8'h10;
  localparam logic [7:0] OFF_GRPB   = 8'h14;
  localparam logic [7:0] OFF_POWER  = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_MODE_BIT = 8;
  localparam int LOOP_LSB      = 4;
  localparam int EMPHA_BIT     = 3;
  localparam int EMPHB_BIT     = 2;
  localparam int GRP_EQ_LSB    = 0;
  localparam int GRP_EMPH_LSB  = 4;
  localparam int GRP_SWING_LSB = 8;
  localparam int PWR_N_BIT     = 0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_OFF  = 2'b00,
    SRC_RX_A = 2'b01,
    SRC_RX_B = 2'b10
  } tx_src_t;

  // Stored code set of one channel group
  typedef struct packed {
    logic [2:0] eqCode;
    logic [2:0] emphLevel;
    logic [1:0] swingCode;
  } grp_cfg_t;

  // Decoded settings of one channel group
  typedef struct packed {
    logic [6:0] eqGain;    // Tenths of a dB
    logic [9:0] swingMv;   // Differential mV
    logic [6:0] emphDb;    // Tenths of a dB
    logic       halfBit;   // 1 = half-bit, 0 = full-bit
  } group_out_t;

  // Routing of one lane
  typedef struct packed {
    logic    rxAOn;
    logic    rxBOn;
    tx_src_t txASrc;
    tx_src_t txBSrc;
    logic    squelchA;
    logic    squelchB;
  } lane_route_t;

  // Whole state of the top module
  typedef struct packed {
    logic              ack;
    logic [31:0]       rdData;
    logic              loaded;
    logic [3:0]        loopN;
    logic              emphModeA;
    logic              emphModeB;
    logic [7:0]        inOff;
    logic [7:0]        outOff;
    grp_cfg_t          cfgA;
    grp_cfg_t          cfgB;
    logic              pdN;
    group_out_t        outA;
    group_out_t        outB;
    logic              pdOut;
    lane_route_t [3:0] route;
  } state_t;

  localparam state_t ST_RESET = '0;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic [6:0] eq_gain_f(input logic [2:0] code);
    case (code)
      3'h0:    eq_gain_f = 7'h08;
      3'h1:    eq_gain_f = 7'h0A;
      3'h2:    eq_gain_f = 7'h0F;
      3'h3:    eq_gain_f = 7'h19;
      3'h4:    eq_gain_f = 7'h23;
      3'h5:    eq_gain_f = 7'h2C;
      3'h6:    eq_gain_f = 7'h3B;
      default: eq_gain_f = 7'h57;
    endcase
  endfunction : eq_gain_f

  function automatic logic [9:0] swing_mv_f(input logic [1:0] code);
    case (code)
      2'h0:    swing_mv_f = 10'h3E8;
      2'h1:    swing_mv_f = 10'h1F4;
      2'h2:    swing_mv_f = 10'h2BC;
      default: swing_mv_f = 10'h384;
    endcase
  endfunction : swing_mv_f

  function automatic logic [6:0] emph_db_f(input logic [2:0] code);
    case (code)
      3'h0:    emph_db_f = 7'h00;
      3'h1:    emph_db_f = 7'h19;
      3'h2:    emph_db_f = 7'h23;
      3'h3:    emph_db_f = 7'h2D;
      3'h4:    emph_db_f = 7'h37;
      3'h5:    emph_db_f = 7'h41;
      3'h6:    emph_db_f = 7'h4B;
      default: emph_db_f = 7'h55;
    endcase
  endfunction : emph_db_f

  // Merge write data into an old word by byte enables
  function automatic logic [31:0] apply_sel_f(input logic [31:0] oldW,
                                              input logic [31:0] newW,
                                              input logic [3:0]  sel);
    apply_sel_f = oldW;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        apply_sel_f[b*8 +: 8] = newW[b*8 +: 8];
      end
    end
  endfunction : apply_sel_f

endpackage : lcfg_pkg

// *** core/lane_route.sv ***
// Per-lane routing, buffer enables and squelch of one lane
`timescale 1ns/1ps
module lane_route
  import lcfg_pkg::*;
(
  // Effective lane controls
  input  wire logic  loopN,
  input  wire logic  inOffA,
  input  wire logic  inOffB,
  input  wire logic  outOffA,
  input  wire logic  outOffB,
  input  wire logic  powerDown,
  // Input level detect
  input  wire logic  sigA,
  input  wire logic  sigB,
  // Result
  output lane_route_t route
);

  // ----------------------------------------------------------------
  // Route decode
  // ----------------------------------------------------------------
  // Power-down wins over everything; a source that is off feeds nothing
  always_comb
  begin
    route = '0;
    route.rxAOn = ~inOffA & ~powerDown;          // [RL16] [RL17]
    route.rxBOn = ~inOffB & ~powerDown;          // [RL16] [RL17]
    // A transmitter only ever carries its own receiver
    if (~outOffA & ~powerDown & route.rxAOn)     // [RL12] [RL13] [RL20]
    begin
      route.txASrc = SRC_RX_A;
    end
    // B transmitter follows A receiver in loopback
    if (~outOffB & ~powerDown)                   // [RL15]
    begin
      if (~loopN)                                // [RL11] [RL13]
      begin
        route.txBSrc = route.rxAOn ? SRC_RX_A : SRC_OFF;
      end
      else                                       // [RL12] [RL20]
      begin
        route.txBSrc = route.rxBOn ? SRC_RX_B : SRC_OFF;
      end
    end
    // Squelch only where a driver is actually on
    route.squelchA = (route.txASrc == SRC_RX_A) & ~sigA;  // [RL10]
    case (route.txBSrc)
      SRC_RX_A: route.squelchB = ~sigA;                   // [RL10]
      SRC_RX_B: route.squelchB = ~sigB;                   // [RL10]
      default:  route.squelchB = 1'b0;
    endcase
  end

endmodule : lane_route

// *** core/lane_config_strap_and_route_ctrl.sv ***
// Top: strap/register configuration select, Wishbone registers, routing
//
// Summary of operation
// [RL1] Mode-select high: straps drive configuration live, bus writes ignored.
// [RL2] Mode-select is never latched; its present level gates bus access.
// [RL3] Mode-select low: all control registers writable, registers set configuration.
// [RL4] Loopback, power-down, de-emphasis, eq and swing straps captured once after reset.
// [RL5] One 3-bit eq code per group, 0.8dB up to 8.7dB in eight steps.
// [RL6] Swing code: 00 1V, 01 0.5V, 10 0.7V, 11 0.9V.
// [RL7] Strength and de-emphasis shared by all channels of a group.
// [RL8] De-emphasis code 000 gives 0dB, then 2.5dB to 8.5dB in 1dB steps.
// [RL9] Half-bit de-emphasis after power-on; register write selects full-bit. Code instead loads the mode from emphModeGroupA/B after reset.
// [RL10] Sub-threshold input squelches the output to common mode.
// [RL11] Active-low loopback strap acts on all lanes; low feeds A receiver to B.
// [RL12] Loop 1, nothing disabled: A to A and B to B.
// [RL13] Loop 0, B input off: A receiver broadcast to both transmitters.
// [RL14] Software picks one loopback setting at start and keeps it.
// [RL15] Disabled inputs and outputs are powered down for mux and demux use.
// [RL16] Input-disable 1 turns input buffer and termination off.
// [RL17] Power-down strap low turns every input and output off.
// [RL18] De-emphasis mode 1 selects half-bit, 0 selects full-bit.
// [RL19] Each setting is muxed: straps when mode-select high, registers when low.
// [RL20] Loop 1, A side off: B receiver to B transmitter, A transmitter off.
`timescale 1ns/1ps
module lane_config_strap_and_route_ctrl
  import lcfg_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Mode and global straps
  input  wire logic        modeSelect,
  input  wire logic        loopbackStrapN,
  input  wire logic        powerdownStrapN,
  input  wire logic        emphModeGroupA,
  input  wire logic        emphModeGroupB,
  // Group straps: bit 2 msb, bit 1 mid, bit 0 lsb
  input  wire logic [2:0]  eqCodeA,
  input  wire logic [2:0]  eqCodeB,
  input  wire logic [1:0]  swingCodeA,
  input  wire logic [1:0]  swingCodeB,
  input  wire logic [2:0]  emphLevelA,
  input  wire logic [2:0]  emphLevelB,
  // Input level detect, one bit per lane
  input  wire logic [3:0]  levelDetectA,
  input  wire logic [3:0]  levelDetectB,
  // Effective configuration
  output group_out_t       groupCfgA,
  output group_out_t       groupCfgB,
  output logic             powerDown,
  output lane_route_t [3:0] laneRoute
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t            st_reg;
  state_t            st_next;

  // Effective controls and helpers
  logic [3:0]        effLoopN;
  logic [7:0]        effInOff;
  logic [7:0]        effOutOff;
  grp_cfg_t          effCfgA;
  grp_cfg_t          effCfgB;
  logic              effHalfA;
  logic              effHalfB;
  logic              effPd;
  lane_route_t [3:0] routeComb;
  logic [7:0]        sigByte;
  logic [7:0]        addrWord;
  logic [31:0]       rdWord;
  logic [31:0]       wrWord;
  logic              busHit;
  logic              busWrite;
  logic              writeOk;

  // ----------------------------------------------------------------
  // Effective configuration select
  // ----------------------------------------------------------------
  // Straps have no per-lane disables, so strap mode runs every buffer on unless the power-down strap is low
  always_comb
  begin
    if (modeSelect)                                      // [RL1] [RL2] [RL19]
    begin
      effLoopN  = {4{loopbackStrapN}};                   // [RL11]
      effInOff  = 8'h00;
      effOutOff = 8'h00;
      effCfgA   = '{eqCodeA, emphLevelA, swingCodeA};
      effCfgB   = '{eqCodeB, emphLevelB, swingCodeB};
      effHalfA  = emphModeGroupA;
      effHalfB  = emphModeGroupB;
      effPd     = ~powerdownStrapN;                      // [RL17]
    end
    else                                                 // [RL3] [RL19]
    begin
      effLoopN  = st_reg.loopN;
      effInOff  = st_reg.inOff;
      effOutOff = st_reg.outOff;
      effCfgA   = st_reg.cfgA;
      effCfgB   = st_reg.cfgB;
      effHalfA  = st_reg.emphModeA;
      effHalfB  = st_reg.emphModeB;
      effPd     = ~st_reg.pdN;
    end
  end

  // ----------------------------------------------------------------
  // Lane routing
  // ----------------------------------------------------------------
  // Lane l: loop bit 3-l, A disable bit 7-2l, B disable bit 6-2l
  for (genvar l = 0; l < 4; l++)
  begin : g_lane
    lane_route u_route (
      .loopN     (effLoopN[3-l]),
      .inOffA    (effInOff[7-2*l]),
      .inOffB    (effInOff[6-2*l]),
      .outOffA   (effOutOff[7-2*l]),
      .outOffB   (effOutOff[6-2*l]),
      .powerDown (effPd),
      .sigA      (levelDetectA[l]),
      .sigB      (levelDetectB[l]),
      .route     (routeComb[l])
    );
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  // Signal detect packed A0,B0,A1,B1.. from bit 7 down
  always_comb
  begin
    sigByte = 8'h00;
    for (int l = 0; l < 4; l++)
    begin
      sigByte[7-2*l] = levelDetectA[l];
      sigByte[6-2*l] = levelDetectB[l];
    end
  end

  assign addrWord = {adr_i[7:2], 2'b00};

  // Unmapped words read as zero
  always_comb
  begin
    rdWord = 32'h0000_0000;
    case (addrWord)
      OFF_STATUS:
      begin
        rdWord[7:0]           = sigByte;
        rdWord[STAT_MODE_BIT] = modeSelect;
      end
      OFF_LOOP:
      begin
        rdWord[LOOP_LSB +: 4] = st_reg.loopN;
        rdWord[EMPHA_BIT]     = st_reg.emphModeA;
        rdWord[EMPHB_BIT]     = st_reg.emphModeB;
      end
      OFF_INOFF:  rdWord[7:0] = st_reg.inOff;
      OFF_OUTOFF: rdWord[7:0] = st_reg.outOff;
      OFF_GRPA:
      begin
        rdWord[GRP_EQ_LSB +: 3]    = st_reg.cfgA.eqCode;
        rdWord[GRP_EMPH_LSB +: 3]  = st_reg.cfgA.emphLevel;
        rdWord[GRP_SWING_LSB +: 2] = st_reg.cfgA.swingCode;
      end
      OFF_GRPB:
      begin
        rdWord[GRP_EQ_LSB +: 3]    = st_reg.cfgB.eqCode;
        rdWord[GRP_EMPH_LSB +: 3]  = st_reg.cfgB.emphLevel;
        rdWord[GRP_SWING_LSB +: 2] = st_reg.cfgB.swingCode;
      end
      OFF_POWER:  rdWord[PWR_N_BIT] = st_reg.pdN;
      default:    rdWord = 32'h0000_0000;
    endcase
  end

  // Read-modify merge keeps untouched byte lanes
  assign wrWord   = apply_sel_f(rdWord, dat_i, sel_i);
  assign busHit   = cyc_i & stb_i;
  assign busWrite = busHit & we_i & st_reg.ack;
  // Mode-select is looked at live on every write
  assign writeOk  = busWrite & ~modeSelect & st_reg.loaded;   // [RL1] [RL2] [RL3]

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    // One wait cycle, then ack for one cycle; refused writes still ack
    st_next.ack = busHit & ~st_reg.ack;
    if (busHit & ~st_reg.ack)
    begin
      st_next.rdData = rdWord;
    end
    if (writeOk)
    begin
      case (addrWord)
        OFF_LOOP:
        begin
          st_next.loopN     = wrWord[LOOP_LSB +: 4];
          st_next.emphModeA = wrWord[EMPHA_BIT];     // [RL9]
          st_next.emphModeB = wrWord[EMPHB_BIT];     // [RL9]
        end
        OFF_INOFF:  st_next.inOff  = wrWord[7:0];    // [RL15]
        OFF_OUTOFF: st_next.outOff = wrWord[7:0];    // [RL15]
        OFF_GRPA:
        begin
          st_next.cfgA.eqCode    = wrWord[GRP_EQ_LSB +: 3];
          st_next.cfgA.emphLevel = wrWord[GRP_EMPH_LSB +: 3];
          st_next.cfgA.swingCode = wrWord[GRP_SWING_LSB +: 2];
        end
        OFF_GRPB:
        begin
          st_next.cfgB.eqCode    = wrWord[GRP_EQ_LSB +: 3];
          st_next.cfgB.emphLevel = wrWord[GRP_EMPH_LSB +: 3];
          st_next.cfgB.swingCode = wrWord[GRP_SWING_LSB +: 2];
        end
        OFF_POWER:  st_next.pdN = wrWord[PWR_N_BIT];
        default:    st_next.pdN = st_reg.pdN;
      endcase
    end
    // Straps are caught once by a clocked capture after reset release
    if (~st_reg.loaded)                                   // [RL4]
    begin
      st_next.loaded    = 1'b1;
      st_next.loopN     = {4{loopbackStrapN}};
      st_next.pdN       = powerdownStrapN;
      st_next.emphModeA = emphModeGroupA;                 // [RL9]
      st_next.emphModeB = emphModeGroupB;                 // [RL9]
      st_next.cfgA      = '{eqCodeA, emphLevelA, swingCodeA};
      st_next.cfgB      = '{eqCodeB, emphLevelB, swingCodeB};
    end
    // Group decode: one setting shared by all four channels of a group
    st_next.outA = '{eq_gain_f(effCfgA.eqCode),           // [RL5] [RL7]
                     swing_mv_f(effCfgA.swingCode),       // [RL6]
                     emph_db_f(effCfgA.emphLevel),        // [RL8]
                     effHalfA};                           // [RL18]
    st_next.outB = '{eq_gain_f(effCfgB.eqCode),           // [RL5] [RL7]
                     swing_mv_f(effCfgB.swingCode),       // [RL6]
                     emph_db_f(effCfgB.emphLevel),        // [RL8]
                     effHalfB};                           // [RL18]
    st_next.pdOut = effPd;                                // [RL17]
    st_next.route = routeComb;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= ST_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign ack_o     = st_reg.ack;
  assign dat_o     = st_reg.rdData;
  assign groupCfgA = st_reg.outA;
  assign groupCfgB = st_reg.outB;
  assign powerDown = st_reg.pdOut;
  assign laneRoute = st_reg.route;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_busWrite(logic [7:0] off);
    cyc_i && stb_i && we_i && ack_o && ({adr_i[7:2], 2'b00} == off);
  endsequence

  sequence s_modeRise;
    !modeSelect ##1 modeSelect;
  endsequence

  sequence s_pdHeld;
    (modeSelect && !powerdownStrapN) [*2];
  endsequence

  property p_strapRefuse;
    (s_busWrite(OFF_INOFF) ##0 (modeSelect && st_reg.loaded)) |=> $stable(st_reg.inOff);
  endproperty
  a_strapRefuse: assert property (p_strapRefuse)  // [RL1]
    else $error("write accepted in strap mode");

  property p_busProgram;
    (s_busWrite(OFF_INOFF) ##0 (!modeSelect && st_reg.loaded && sel_i[0]))
      |=> st_reg.inOff == $past(dat_i[7:0]);
  endproperty
  a_busProgram: assert property (p_busProgram)  // [RL3]
    else $error("bus write did not program register");

  property p_modeLive;
    s_modeRise |=> groupCfgA.eqGain == eq_gain_f($past(eqCodeA));
  endproperty
  a_modeLive: assert property (p_modeLive)  // [RL2]
    else $error("strap not applied after mode rise");

  property p_powerOnCapture;
    $rose(st_reg.loaded) |-> (st_reg.cfgB.eqCode == $past(eqCodeB))
      && (st_reg.loopN == {4{$past(loopbackStrapN)}})
      && (st_reg.pdN == $past(powerdownStrapN));
  endproperty
  a_powerOnCapture: assert property (p_powerOnCapture)  // [RL4]
    else $error("straps not captured at start");

  property p_eqGroup;
    !modeSelect |=> groupCfgA.eqGain == eq_gain_f($past(st_reg.cfgA.eqCode));
  endproperty
  a_eqGroup: assert property (p_eqGroup)  // [RL5]
    else $error("eq gain not from register");

  property p_swing;
    modeSelect |=> groupCfgB.swingMv == swing_mv_f($past(swingCodeB));
  endproperty
  a_swing: assert property (p_swing)  // [RL6]
    else $error("swing decode wrong");

  property p_emph;
    modeSelect |=> groupCfgA.emphDb == emph_db_f($past(emphLevelA));
  endproperty
  a_emph: assert property (p_emph)  // [RL8]
    else $error("de-emphasis decode wrong");

  property p_halfBit;
    modeSelect |=> groupCfgB.halfBit == $past(emphModeGroupB);
  endproperty
  a_halfBit: assert property (p_halfBit)  // [RL18]
    else $error("de-emphasis mode wrong");

  property p_normal;
    (modeSelect && loopbackStrapN && powerdownStrapN)
      |=> (laneRoute[2].txASrc == SRC_RX_A) && (laneRoute[2].txBSrc == SRC_RX_B);
  endproperty
  a_normal: assert property (p_normal)  // [RL12]
    else $error("normal routing wrong");

  property p_broadcast;
    (!modeSelect && st_reg.pdN && !st_reg.loopN[3] && !st_reg.inOff[7]
      && st_reg.inOff[6] && (st_reg.outOff[7:6] == 2'h0))
      |=> (laneRoute[0].txASrc == SRC_RX_A) && (laneRoute[0].txBSrc == SRC_RX_A);
  endproperty
  a_broadcast: assert property (p_broadcast)  // [RL13]
    else $error("broadcast routing wrong");

  property p_squelch;
    (modeSelect && powerdownStrapN && !levelDetectA[1]) |=> laneRoute[1].squelchA;
  endproperty
  a_squelch: assert property (p_squelch)  // [RL10]
    else $error("squelch missing");

  property p_powerDown;
    s_pdHeld |-> powerDown && (laneRoute == '0);
  endproperty
  a_powerDown: assert property (p_powerDown)  // [RL17]
    else $error("buffers on in power-down");

endmodule : lane_config_strap_and_route_ctrl

// *** bench/strap_board.sv ***
// Board model: strap jumpers and input level detect facing the block
`timescale 1ns/1ps
module strap_board
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Requested jumpers and line activity
  input  wire logic [19:0] jumperReq,
  input  wire logic [7:0]  activeReq,
  // Strap pins and level detect
  output logic      [19:0] straps,
  output logic      [7:0]  detect
);
  // ----------------------------------------------------------------
  // Jumpers settle one edge after a change
  // ----------------------------------------------------------------
  // Loopback jumper is only taken while reset is held, so it never moves under traffic
  always_ff @(posedge core_clk)
  begin
    straps <= {jumperReq[19:1], arst_n ? straps[0] : jumperReq[0]};
    detect <= activeReq;
  end
endmodule : strap_board

// *** bench/lane_config_strap_and_route_ctrl_tb.sv ***
// Self-checking bench of the lane configuration block
`timescale 1ns/1ps
module lane_config_strap_and_route_ctrl_tb;
  import lcfg_pkg::*;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  logic              core_clk, arst_n, cyc, stb, we, modeSel, ack_o, powerDown;
  logic [7:0]        adr, actReq, det;
  logic [3:0]        sel;
  logic [31:0]       wdat, dat_o, rd;
  logic [19:0]       jReq, j0, straps;
  group_out_t        groupCfgA, groupCfgB;
  lane_route_t [3:0] laneRoute;
  int                fail_count, compares, cycles, seed;
  logic [6:0]        eqT [8] = '{7'h08, 7'h0A, 7'h0F, 7'h19, 7'h23, 7'h2C, 7'h3B, 7'h57};
  logic [9:0]        swT [4] = '{10'h3E8, 10'h1F4, 10'h2BC, 10'h384};
  logic [7:0]        mLoop [3] = '{8'hF4, 8'h74, 8'hF4};
  logic [7:0]        mIn [3] = '{8'h00, 8'h40, 8'h80};
  logic [7:0]        mRoute [3] = '{8'hD8, 8'h94, 8'h48};

  strap_board strap_board_inst (.core_clk(core_clk), .arst_n(arst_n), .jumperReq(jReq),
    .activeReq(actReq), .straps(straps), .detect(det));

  lane_config_strap_and_route_ctrl lane_config_strap_and_route_ctrl_inst (
    .core_clk(core_clk), .arst_n(arst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .modeSelect(modeSel),
    .loopbackStrapN(straps[0]), .powerdownStrapN(straps[1]), .emphModeGroupA(straps[2]),
    .emphModeGroupB(straps[3]), .eqCodeA(straps[6:4]), .eqCodeB(straps[9:7]),
    .swingCodeA(straps[11:10]), .swingCodeB(straps[13:12]), .emphLevelA(straps[16:14]),
    .emphLevelB(straps[19:17]), .levelDetectA(det[3:0]), .levelDetectB(det[7:4]),
    .groupCfgA(groupCfgA), .groupCfgB(groupCfgB), .powerDown(powerDown),
    .laneRoute(laneRoute));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expected decoded group, in tenths of a dB and mV
  function automatic logic [31:0] expG(input logic [2:0] e, input logic [2:0] d,
                                       input logic [1:0] s, input logic h);
    group_out_t g;
    g.eqGain = eqT[e];
    g.swingMv = swT[s];
    g.emphDb = (d == 3'h0) ? 7'h00 : 7'h0F + 7'h0A * d;
    g.halfBit = h;
    return 32'(g);
  endfunction : expG

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle; holds everything until ack is seen high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge core_clk); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Settle after registered outputs update
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wt

  task automatic close_out();
    $display("Mismatches %0d of %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Whole run is well under two thousand cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 75;
    {cyc, stb, we, adr, wdat, sel} = '0;
    sel = 4'hF;
    modeSel = 1'b1;
    actReq = 8'hFF;
    jReq = 20'($random(seed)) | 20'h00003;
    j0 = jReq;
    arst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    wt(3);
    // Strap mode decodes live straps
    chk(32'(groupCfgA), expG(j0[6:4], j0[16:14], j0[11:10], j0[2]));
    chk(32'(groupCfgB), expG(j0[9:7], j0[19:17], j0[13:12], j0[3]));
    chk(32'(laneRoute[3].txBSrc), 32'(SRC_RX_B));
    @(posedge core_clk);
    jReq <= jReq ^ 20'hFFFFC;
    wt(3);
    chk(32'(groupCfgA), expG(~j0[6:4], ~j0[16:14], ~j0[11:10], ~j0[2]));
    // Bus write refused, captured startup values read back
    wb(1'b1, OFF_GRPA, 32'h0);
    wb(1'b0, OFF_GRPA, 32'h0);
    chk(rd, 32'({j0[11:10], 1'b0, j0[16:14], 1'b0, j0[6:4]}));
    wb(1'b0, OFF_LOOP, 32'h0);
    chk(rd, 32'({{4{j0[0]}}, j0[2], j0[3], 2'b00}));
    wb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_01FF);
    // Register mode: captured values now drive
    @(posedge core_clk);
    modeSel <= 1'b0;
    wt(3);
    chk(32'(groupCfgA), expG(j0[6:4], j0[16:14], j0[11:10], j0[2]));
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b1, OFF_GRPA, 32'({i[1:0], 1'b0, i[2:0], 1'b0, 3'(7 - i)}));
      wt(3);
      chk(32'(groupCfgA), expG(3'(7 - i), i[2:0], i[1:0], j0[2]));
    end
    // Full-bit chosen for group A by register
    wb(1'b1, OFF_LOOP, 32'h0000_00F4);
    wt(3);
    chk(32'(groupCfgA.halfBit), 32'h0);
    // Normal, broadcast and B-only routing of lane 0
    for (int m = 0; m < 3; m++)
    begin
      wb(1'b1, OFF_LOOP, 32'(mLoop[m]));
      wb(1'b1, OFF_INOFF, 32'(mIn[m]));
      wb(1'b1, OFF_OUTOFF, 32'(m == 2 ? 8'h80 : 8'h00));
      wt(3);
      chk(32'(laneRoute[0]), 32'(mRoute[m]));
    end
    // Quiet B input squelches the B transmitter
    @(posedge core_clk);
    actReq <= 8'hEF;
    wt(3);
    chk(32'(laneRoute[0]), 32'h49);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_00BF);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, OFF_POWER, 32'h0);
    wt(3);
    chk(32'(powerDown), 32'h1);
    // Second reset with loopback jumper low
    @(posedge core_clk);
    modeSel <= 1'b1;
    jReq <= {jReq[19:1], 1'b0};
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    wt(3);
    chk(32'(laneRoute[2].txBSrc), 32'(SRC_RX_A));
    // Random live straps and level detect, power-down strap included
    for (int k = 0; k < 8; k++)
    begin
      @(posedge core_clk);
      jReq <= 20'($random(seed));
      actReq <= 8'($random(seed));
      wt(3);
      chk(32'(groupCfgB), expG(jReq[9:7], jReq[19:17], jReq[13:12], jReq[3]));
      chk(32'(powerDown), 32'(!jReq[1]));
      chk(32'(laneRoute[1].squelchA), 32'(jReq[1] && !actReq[1]));
    end
    close_out();
  end
endmodule : lane_config_strap_and_route_ctrl_tb
